/* File: verilog/pmicfs_consts.svh */
// Constants for the identification and fault status register bank
// Notes on behaviour
// [RULE_01] Part code register at 0x0A is read-only, fixed, writes ignored.
// [RULE_02] Maker code register at 0x0B returns a fixed constant on every read.
// [RULE_03] Silicon revision register at 0x0C is fixed; writes do nothing.
// [RULE_04] Fault status 0x0D: bit 7 core rail, bit 6 memory rail undervolt.
// [RULE_05] Fault status: bit 5 flash I/O rail, bit 4 linear rail undervolt.
// [RULE_06] Fault status bit 3 shows die over-temperature detected.
// [RULE_07] Fault status bit 2 shows input supply over-voltage detected.
// [RULE_08] Bits 1 and 0 show gate-drive-ready and output power-on-reset monitors.
// [RULE_09] Any rail undervolt latches a fault state, no automatic recovery.
// [RULE_10] Other faults only drop the rail and restore it once cleared.
// [RULE_11] Deep standby states requested by bus command or standby pins.
// [RULE_12] Power-good and undervolt of each rail readable over the bus.
// [RULE_13] Bus sets wake sequence, rail on/off, skip mode, sleep, core voltage.
// [RULE_14] Core voltage code selects 0.7 V to 1.3 V in 10 mV steps.
// [RULE_15] Latched undervolt turns all rails off, power-good low, until reset.
// [RULE_16] Rail overvolt drops power-good and that rail until all indicators release. The code re-enables each rail once its own indicator releases.
// [RULE_17] Reading fault status has no side effect; flags are not cleared.
`ifndef PMICFS_CONSTS_SVH
`define PMICFS_CONSTS_SVH

// Register offsets
`define PMICFS_OFS_RAIL_CTRL   8'h01
`define PMICFS_OFS_SLEEP_CTRL  8'h02
`define PMICFS_OFS_CORE_CODE   8'h03
`define PMICFS_OFS_WAKE_A      8'h05
`define PMICFS_OFS_WAKE_B      8'h06
`define PMICFS_OFS_WAKE_C      8'h07
`define PMICFS_OFS_PART        8'h0A
`define PMICFS_OFS_MAKER       8'h0B
`define PMICFS_OFS_REVISION    8'h0C
`define PMICFS_OFS_FAULT       8'h0D
`define PMICFS_OFS_RAIL_STAT   8'h0E

// Field positions
`define PMICFS_FLD_UV_CORE     7
`define PMICFS_FLD_UV_MEM      6
`define PMICFS_FLD_UV_FLASH    5
`define PMICFS_FLD_UV_LINEAR   4
`define PMICFS_FLD_OVERTEMP    3
`define PMICFS_FLD_INPUT_OV    2
`define PMICFS_FLD_GATE_READY  1
`define PMICFS_FLD_OUT_POR     0
`define PMICFS_FLD_SLEEP       0
`define PMICFS_FLD_DEEP        1
`define PMICFS_FLD_ALIVE_HI    4
`define PMICFS_FLD_ALIVE_LO    0

// Reset values
`define PMICFS_RST_RAIL_CTRL   8'h0F
`define PMICFS_RST_SLEEP_CTRL  8'h00
`define PMICFS_RST_CORE_CODE   8'h14
`define PMICFS_RST_WAKE_A      8'h00
`define PMICFS_RST_WAKE_B      8'hE1
`define PMICFS_RST_WAKE_C      8'h8A
`define PMICFS_RST_UNMAPPED    8'h00

// Core voltage code range: 0.7 V plus code times 10 mV, top 1.3 V
`define PMICFS_CORE_MV_BASE    700
`define PMICFS_CORE_MV_STEP    10
`define PMICFS_CORE_MV_TOP     1300
`define PMICFS_CORE_CODE_MAX   8'h3C

`endif

/* File: verilog/pmicfs_pkg.sv */
// Types for the identification and fault status register bank
`default_nettype none
package pmicfs_pkg;
    typedef enum logic [3:0] {
        PMICFS_IDLE, PMICFS_ADDR, PMICFS_ACK_ADDR, PMICFS_RX_REG, PMICFS_ACK_REG,
        PMICFS_RX_DATA, PMICFS_ACK_DATA, PMICFS_TX, PMICFS_ACK_WAIT
    } pmicfs_bus_state_t;

    typedef enum logic [1:0] {
        PMICFS_PS_ACTIVE, PMICFS_PS_DEEP_IDLE, PMICFS_PS_DEEP_OFF
    } pmicfs_power_state_t;
endpackage
`default_nettype wire

/* File: verilog/pmicfs_bank.sv */
// Two-wire bus slave with identification, fault status and rail control registers
`include "pmicfs_consts.svh"
`default_nettype none
module pmicfs_bank
    import pmicfs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = 7'h12, // Bus address, arbitrary default
    parameter logic [7:0] PART_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] REV_CODE  = 8'h01, // Arbitrary value
    parameter int         NUM_RAILS = 4
) (
    // Clock and reset (reset is the input supply power-on reset)
    input  wire logic                clock,
    input  wire logic                srst,
    // Two-wire serial bus
    input  wire logic                scl,
    input  wire logic                sdaIn,
    output logic                     sdaOut,
    output logic                     sdaOeN,
    // Analog monitor inputs, already deglitched
    input  wire logic [3:0]          railUndervolt,
    input  wire logic [3:0]          railOvervolt,
    input  wire logic [3:0]          railPowerGood,
    input  wire logic                dieOvertemp,
    input  wire logic                inputOvervolt,
    input  wire logic                gateReady,
    input  wire logic                outputPorMonitor,
    // Power state pins from host
    input  wire logic                standbyN,
    input  wire logic                deepIdleRequestPin,
    // Rail control outputs
    output logic [3:0]               railEnable,
    output logic [3:0]               pulseSkipOperation,
    output logic [7:0]               coreVoltCode,
    output logic [7:0]               wakeTimingA,
    output logic [7:0]               wakeTimingB,
    output logic [7:0]               wakeTimingC,
    output pmicfs_power_state_t      powerState,
    output logic                     powerGoodOut
);

    // Logic is written for exactly four rails
    if (NUM_RAILS != 4) begin : gRailCheck
        $error("pmicfs_bank serves exactly four rails");
    end

    pmicfs_bus_state_t state;
    logic              sclPrev;
    logic              sdaPrev;
    logic [7:0]        shiftReg;
    logic [2:0]        bitCnt;
    logic              gotByte;
    logic              readMode;
    logic [7:0]        regPtr;
    logic              driveLow;
    logic [3:0]        uvLatch;
    logic [7:0]        railCtrl;
    logic [7:0]        sleepCtrl;
    logic [7:0]        readData;
    logic [7:0]        faultStatus;
    logic [7:0]        railStatus;
    logic [3:0]        aliveMask;
    logic              sleeping;
    logic              anyOvervolt;
    logic              anyUvLatched;
    logic [7:0]        next_shift;

    // Bus line events; inputs are already in the clock domain
    wire sclRise   = scl & ~sclPrev;
    wire sclFall   = ~scl & sclPrev;
    wire busStart  = scl & sclPrev & sdaPrev & ~sdaIn;
    wire busStop   = scl & sclPrev & ~sdaPrev & sdaIn;
    wire writeHit  = (state == PMICFS_RX_DATA) && sclFall && gotByte;

    // Clamp a written core code so the rail never leaves 0.7 V to 1.3 V
    function automatic logic [7:0] clampCode(input logic [7:0] code);
        clampCode = (code > `PMICFS_CORE_CODE_MAX) ? `PMICFS_CORE_CODE_MAX : code;
    endfunction

    // Line history for edge detection
    always_ff @(posedge clock) begin
        if (srst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sdaIn;
        end
    end

    // Fault status word; a read only samples it, nothing is cleared
    always_comb begin
        faultStatus = 8'h00;
        faultStatus[`PMICFS_FLD_UV_CORE]    = uvLatch[0];       // RULE_04
        faultStatus[`PMICFS_FLD_UV_MEM]     = uvLatch[1];       // RULE_04
        faultStatus[`PMICFS_FLD_UV_FLASH]   = uvLatch[2];       // RULE_05
        faultStatus[`PMICFS_FLD_UV_LINEAR]  = uvLatch[3];       // RULE_05
        faultStatus[`PMICFS_FLD_OVERTEMP]   = dieOvertemp;      // RULE_06
        faultStatus[`PMICFS_FLD_INPUT_OV]   = inputOvervolt;    // RULE_07
        faultStatus[`PMICFS_FLD_GATE_READY] = gateReady;        // RULE_08
        faultStatus[`PMICFS_FLD_OUT_POR]    = outputPorMonitor; // RULE_08
        railStatus = {uvLatch, railPowerGood};                  // RULE_12
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        case (regPtr)
            `PMICFS_OFS_RAIL_CTRL:  readData = railCtrl;
            `PMICFS_OFS_SLEEP_CTRL: readData = sleepCtrl;
            `PMICFS_OFS_CORE_CODE:  readData = coreVoltCode;
            `PMICFS_OFS_WAKE_A:     readData = wakeTimingA;
            `PMICFS_OFS_WAKE_B:     readData = wakeTimingB;
            `PMICFS_OFS_WAKE_C:     readData = wakeTimingC;
            `PMICFS_OFS_PART:       readData = PART_CODE;  // RULE_01
            `PMICFS_OFS_MAKER:      readData = MAKER_CODE; // RULE_02
            `PMICFS_OFS_REVISION:   readData = REV_CODE;   // RULE_03
            `PMICFS_OFS_FAULT:      readData = faultStatus; // RULE_17
            `PMICFS_OFS_RAIL_STAT:  readData = railStatus; // RULE_12
            default:                readData = `PMICFS_RST_UNMAPPED;
        endcase
    end

    // Shift register input, sampled on bus clock rise
    always_comb begin
        next_shift = shiftReg;
        if (sclRise && state != PMICFS_TX) begin
            next_shift = {shiftReg[6:0], sdaIn};
        end
    end

    // Bus protocol state machine
    always_ff @(posedge clock) begin
        if (srst) begin
            state    <= PMICFS_IDLE;
            shiftReg <= 8'h00;
            bitCnt   <= 3'd0;
            gotByte  <= 1'b0;
            readMode <= 1'b0;
            regPtr   <= 8'h00;
            driveLow <= 1'b0;
        end else if (busStart) begin
            // Repeated start keeps the pointer so reads follow a register write
            state    <= PMICFS_ADDR;
            bitCnt   <= 3'd0;
            gotByte  <= 1'b0;
            driveLow <= 1'b0;
        end else if (busStop) begin
            state    <= PMICFS_IDLE;
            driveLow <= 1'b0;
            gotByte  <= 1'b0;
        end else begin
            shiftReg <= next_shift;
            if (sclRise && (state == PMICFS_ADDR || state == PMICFS_RX_REG ||
                            state == PMICFS_RX_DATA)) begin
                bitCnt <= bitCnt + 3'd1;
                if (bitCnt == 3'd7) begin
                    gotByte <= 1'b1;
                end
            end
            case (state)
                PMICFS_IDLE: begin
                    driveLow <= 1'b0;
                end
                PMICFS_ADDR: begin
                    if (sclFall && gotByte) begin
                        gotByte <= 1'b0;
                        if (shiftReg[7:1] == DEV_ADDR) begin
                            readMode <= shiftReg[0];
                            driveLow <= 1'b1;
                            state    <= PMICFS_ACK_ADDR;
                        end else begin
                            state <= PMICFS_IDLE;
                        end
                    end
                end
                PMICFS_ACK_ADDR: begin
                    if (sclFall) begin
                        bitCnt <= 3'd0;
                        if (readMode) begin
                            shiftReg <= readData;
                            driveLow <= ~readData[7];
                            regPtr   <= regPtr + 8'h01;
                            state    <= PMICFS_TX;
                        end else begin
                            driveLow <= 1'b0;
                            state    <= PMICFS_RX_REG;
                        end
                    end
                end
                PMICFS_RX_REG: begin
                    if (sclFall && gotByte) begin
                        gotByte  <= 1'b0;
                        regPtr   <= shiftReg;
                        driveLow <= 1'b1;
                        state    <= PMICFS_ACK_REG;
                    end
                end
                PMICFS_ACK_REG, PMICFS_ACK_DATA: begin
                    if (sclFall) begin
                        driveLow <= 1'b0;
                        bitCnt   <= 3'd0;
                        state    <= PMICFS_RX_DATA;
                    end
                end
                PMICFS_RX_DATA: begin
                    if (writeHit) begin
                        gotByte  <= 1'b0;
                        regPtr   <= regPtr + 8'h01;
                        driveLow <= 1'b1;
                        state    <= PMICFS_ACK_DATA;
                    end
                end
                PMICFS_TX: begin
                    if (sclFall) begin
                        bitCnt <= bitCnt + 3'd1;
                        if (bitCnt == 3'd7) begin
                            driveLow <= 1'b0;
                            state    <= PMICFS_ACK_WAIT;
                        end else begin
                            shiftReg <= {shiftReg[6:0], 1'b0};
                            driveLow <= ~shiftReg[6];
                        end
                    end
                end
                PMICFS_ACK_WAIT: begin
                    // Host NACK ends the read; host ACK asks for the next byte
                    if (sclRise) begin
                        readMode <= ~sdaIn;
                    end
                    if (sclFall) begin
                        bitCnt <= 3'd0;
                        if (readMode) begin
                            shiftReg <= readData;
                            driveLow <= ~readData[7];
                            regPtr   <= regPtr + 8'h01;
                            state    <= PMICFS_TX;
                        end else begin
                            state <= PMICFS_IDLE;
                        end
                    end
                end
                default: begin
                    state    <= PMICFS_IDLE;
                    driveLow <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain data line: only ever pulls low
    always_ff @(posedge clock) begin
        if (srst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end
    assign sdaOeN = ~driveLow;

    // Writable control registers; read-only offsets fall through
    always_ff @(posedge clock) begin
        if (srst) begin
            railCtrl     <= `PMICFS_RST_RAIL_CTRL;
            sleepCtrl    <= `PMICFS_RST_SLEEP_CTRL;
            coreVoltCode <= `PMICFS_RST_CORE_CODE;
            wakeTimingA  <= `PMICFS_RST_WAKE_A;
            wakeTimingB  <= `PMICFS_RST_WAKE_B;
            wakeTimingC  <= `PMICFS_RST_WAKE_C;
        end else if (writeHit) begin
            case (regPtr)
                `PMICFS_OFS_RAIL_CTRL:  railCtrl     <= shiftReg; // RULE_13
                `PMICFS_OFS_SLEEP_CTRL: sleepCtrl    <= shiftReg; // RULE_13
                `PMICFS_OFS_CORE_CODE:  coreVoltCode <= clampCode(shiftReg); // RULE_14
                `PMICFS_OFS_WAKE_A:     wakeTimingA  <= shiftReg; // RULE_13
                `PMICFS_OFS_WAKE_B:     wakeTimingB  <= shiftReg;
                `PMICFS_OFS_WAKE_C:     wakeTimingC  <= shiftReg;
                default: ; // RULE_01 RULE_03
            endcase
        end
    end

    // Undervolt latch; only the power-on reset releases it
    always_ff @(posedge clock) begin
        if (srst) begin
            uvLatch <= 4'h0;
        end else begin
            uvLatch <= uvLatch | railUndervolt; // RULE_09
        end
    end

    // Power state from bus bits or host pins, either source may request
    always_ff @(posedge clock) begin
        if (srst) begin
            powerState <= PMICFS_PS_ACTIVE;
        end else if (~standbyN || sleepCtrl[`PMICFS_FLD_SLEEP]) begin // RULE_11
            if (deepIdleRequestPin || ~sleepCtrl[`PMICFS_FLD_DEEP]) begin
                powerState <= PMICFS_PS_DEEP_IDLE;
            end else begin
                powerState <= PMICFS_PS_DEEP_OFF;
            end
        end else begin
            powerState <= PMICFS_PS_ACTIVE;
        end
    end

    assign sleeping     = (powerState != PMICFS_PS_ACTIVE);
    assign anyOvervolt  = |railOvervolt;
    assign anyUvLatched = |uvLatch;
    // Alive bits: core/memory in wake A, flash/linear in wake B
    assign aliveMask    = {wakeTimingB[`PMICFS_FLD_ALIVE_LO], wakeTimingB[`PMICFS_FLD_ALIVE_HI],
                           wakeTimingA[`PMICFS_FLD_ALIVE_LO], wakeTimingA[`PMICFS_FLD_ALIVE_HI]};

    // Per-rail enable; self-recovering faults gate it live, no memory kept
    for (genvar r = 0; r < 4; r++) begin : gRail
        always_ff @(posedge clock) begin
            if (srst) begin
                railEnable[r]         <= 1'b0;
                pulseSkipOperation[r] <= 1'b0;
            end else begin
                railEnable[r] <= railCtrl[r] & ~anyUvLatched // RULE_15
                               & ~dieOvertemp & ~inputOvervolt // RULE_10
                               & ~railOvervolt[r] // RULE_16
                               & (~sleeping | aliveMask[r]);
                pulseSkipOperation[r] <= railCtrl[r + 4]; // RULE_13
            end
        end
    end

    // Power-good: low on latched undervolt or any overvolt indicator
    always_ff @(posedge clock) begin
        if (srst) begin
            powerGoodOut <= 1'b0;
        end else begin
            powerGoodOut <= ~anyUvLatched & ~anyOvervolt // RULE_15 RULE_16
                          & ~dieOvertemp & ~inputOvervolt
                          & ((railPowerGood | ~railEnable) == 4'hF) & (|railEnable);
        end
    end

endmodule
`default_nettype wire

/* File: bench/pmicfs_bank_properties.sv */
// Concurrent checks on the fault, rail and power state ports of the bank
`default_nettype none
module pmicfs_bank_properties
    import pmicfs_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       srst,
    // Monitors and host pins
    input wire logic [3:0] railUndervolt,
    input wire logic [3:0] railOvervolt,
    input wire logic       dieOvertemp,
    input wire logic       inputOvervolt,
    input wire logic       standbyN,
    input wire logic       deepIdleRequestPin,
    // Outputs under watch
    input wire logic [3:0] railEnable,
    input wire logic [7:0] coreVoltCode,
    input wire logic [1:0] powerState,
    input wire logic       powerGoodOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // Undervolt must hold everything down, not just for one cycle
    AST_UV_LATCH: assert property (
        |railUndervolt |-> ##2 (railEnable == 4'h0 && !powerGoodOut)[*8])
        else $error("rails up after undervolt");
    AST_RAIL_OV: assert property (1'b1 |=> (railEnable & $past(railOvervolt)) == 4'h0)
        else $error("rail on in overvolt");
    AST_PG_FAULT: assert property (
        (dieOvertemp || inputOvervolt || |railOvervolt) |=> !powerGoodOut)
        else $error("power good in fault");
    AST_OT_OFF: assert property (dieOvertemp |=> railEnable == 4'h0)
        else $error("rails on while die hot");
    AST_VIN_OFF: assert property (inputOvervolt |=> railEnable == 4'h0)
        else $error("rails on in input overvolt");
    AST_SLEEP_PIN: assert property (!standbyN |=> powerState != PMICFS_PS_ACTIVE)
        else $error("standby pin ignored");
    AST_DEEP_IDLE: assert property (
        (!standbyN && deepIdleRequestPin) |=> powerState == PMICFS_PS_DEEP_IDLE)
        else $error("deep idle pin ignored");
    AST_CORE_MAX: assert property (coreVoltCode <= 8'h3C)
        else $error("core code over top");

    // Main scenarios reached
    cover property (|railUndervolt);
    cover property (powerState == PMICFS_PS_DEEP_OFF);
    cover property ($rose(powerGoodOut));
endmodule

bind pmicfs_bank pmicfs_bank_properties chk (.*);
`default_nettype wire

/* File: bench/pmicfs_bus_host.sv */
// Two-wire bus host model standing in for the drive controller
`default_nettype none
module pmicfs_bus_host #(
    parameter logic [6:0] DEV = 7'h12
) (
    // Clock
    input  wire logic clock,
    // Bus wires; sdaRel high lets the pull-up win
    output logic      scl,
    output logic      sdaRel,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end

    // Step off the edge so the device never sees a race
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // Low and high phases of two clocks or more
    task automatic clkBit(output logic smp);
        tk(2);
        scl = 1'b1;
        tk(2);
        smp = sdaLine;
        tk(1);
        scl = 1'b0;
        tk(1);
    endtask

    // Start or repeated start; data falls while the clock line is high
    task automatic st();
        sdaRel = 1'b1;
        tk(1);
        scl = 1'b1;
        tk(2);
        sdaRel = 1'b0;
        tk(2);
        scl = 1'b0;
        tk(1);
    endtask

    // Stop
    task automatic sp();
        sdaRel = 1'b0;
        tk(1);
        scl = 1'b1;
        tk(2);
        sdaRel = 1'b1;
        tk(2);
    endtask

    // One byte out, MSB first; ok drops on a missing ack
    task automatic tx(input logic [7:0] b, inout logic ok);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sdaRel = b[i];
            clkBit(s);
        end
        sdaRel = 1'b1;
        clkBit(s);
        ok = ok & ~s;
    endtask

    // One byte in, then a nack to end the read
    task automatic rx(output logic [7:0] b);
        logic s;
        sdaRel = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            clkBit(s);
            b[i] = s;
        end
        clkBit(s);
    endtask

    // Register write: address, pointer, data
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
        ok = 1'b1;
        st();
        tx({DEV, 1'b0}, ok);
        tx(ofs, ok);
        tx(d, ok);
        sp();
    endtask

    // Register read through a repeated start
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
        ok = 1'b1;
        st();
        tx({DEV, 1'b0}, ok);
        tx(ofs, ok);
        st();
        tx({DEV, 1'b1}, ok);
        rx(d);
        sp();
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the identification and fault status bank
`default_nettype none
module testbench
    import pmicfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV   = 7'h2D; // Arbitrary bus address
    localparam logic [7:0] PART  = 8'h6B; // Arbitrary value
    localparam logic [7:0] MAKER = 8'h9E; // Arbitrary value
    localparam logic [7:0] REV   = 8'h04; // Arbitrary value

    logic       clock, srst, scl, sdaRel, sdaOut, sdaOeN, powerGoodOut, ok;
    logic       dieOt, vinOv, gateReady, porMon, standbyN, deepPin;
    logic [3:0] uv, ov, pgIn, railEnable, pulseSkip;
    logic [7:0] coreCode, wakeA, wakeB, wakeC, rdData;
    int         nErrors = 0;
    int         nChecks = 0;
    logic [1:0] powerState;
    // Open-drain data wire with pull-up
    wire        sdaLine = sdaRel & (sdaOeN | sdaOut);

    // Clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    pmicfs_bank #(.DEV_ADDR(DEV), .PART_CODE(PART), .MAKER_CODE(MAKER), .REV_CODE(REV)) dut (
        .clock(clock), .srst(srst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .railUndervolt(uv), .railOvervolt(ov), .railPowerGood(pgIn),
        .dieOvertemp(dieOt), .inputOvervolt(vinOv), .gateReady(gateReady),
        .outputPorMonitor(porMon), .standbyN(standbyN), .deepIdleRequestPin(deepPin),
        .railEnable(railEnable), .pulseSkipOperation(pulseSkip), .coreVoltCode(coreCode),
        .wakeTimingA(wakeA), .wakeTimingB(wakeB), .wakeTimingC(wakeC),
        .powerState(powerState), .powerGoodOut(powerGoodOut));

    pmicfs_bus_host #(.DEV(DEV)) host (.clock(clock), .scl(scl), .sdaRel(sdaRel),
        .sdaLine(sdaLine));

    // Edge plus a fixed small delay
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus access with its ack judged too
    task automatic rchk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
        host.rd(ofs, rdData, ok);
        chk("read ack", 8'h01, 8'(ok));
        chk(what, exp, rdData);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.wr(ofs, d, ok);
        chk("write ack", 8'h01, 8'(ok));
    endtask

    task automatic tReset();
        srst = 1'b1;
        cyc(5);
        chk("reset rails", 8'h00, 8'(railEnable));
        chk("reset core code", 8'h14, coreCode);
        chk("reset wake", 8'hE1, wakeB);
        chk("reset wake A", 8'h00, wakeA);
        chk("reset wake C", 8'h8A, wakeC);
        srst = 1'b0;
        cyc(3);
        chk("rails up", 8'h0F, 8'(railEnable));
        chk("power good up", 8'h01, 8'(powerGoodOut));
        $display("test reset done");
    endtask

    // Fixed codes survive writes; unmapped space reads zero
    task automatic tIdent();
        for (int i = 10; i <= 13; i++) begin
            wr(8'(i), 8'hFF);
        end
        rchk("part code", 8'h0A, PART);
        rchk("maker code", 8'h0B, MAKER);
        rchk("revision", 8'h0C, REV);
        rchk("status clean", 8'h0D, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        $display("test ident done");
    endtask

    // Core code across and past the top; rail and skip control
    task automatic tCore();
        logic [7:0] codes [4] = '{8'h00, 8'h3C, 8'h3D, 8'hFF};
        logic [7:0] e;
        foreach (codes[i]) begin
            e = (codes[i] > 8'h3C) ? 8'h3C : codes[i];
            wr(8'h03, codes[i]);
            chk("core code out", e, coreCode);
            rchk("core code back", 8'h03, e);
        end
        wr(8'h01, 8'h35);
        cyc(2);
        chk("rails by bus", 8'h05, 8'(railEnable));
        chk("skip by bus", 8'h03, 8'(pulseSkip));
        wr(8'h01, 8'h0F);
        $display("test core done");
    endtask

    // Self-recovering faults and live status bits
    task automatic tFault();
        gateReady = 1'b1;
        dieOt = 1'b1;
        cyc(2);
        chk("rails hot", 8'h00, 8'(railEnable));
        rchk("status hot", 8'h0D, 8'h0A);
        rchk("status hot again", 8'h0D, 8'h0A);
        {dieOt, vinOv, gateReady, porMon} = 4'h5;
        rchk("status vin", 8'h0D, 8'h05);
        vinOv = 1'b0;
        porMon = 1'b0;
        cyc(3);
        chk("rails back", 8'h0F, 8'(railEnable));
        ov = 4'h2;
        cyc(2);
        chk("rail ov off", 8'h0D, 8'(railEnable));
        chk("pg ov", 8'h00, 8'(powerGoodOut));
        ov = 4'h0;
        cyc(3);
        chk("pg ov back", 8'h01, 8'(powerGoodOut));
        $display("test fault done");
    endtask

    // Deep states by pins and by bus
    task automatic tSleep();
        standbyN = 1'b0;
        deepPin = 1'b1;
        cyc(2);
        chk("pin idle", 8'(PMICFS_PS_DEEP_IDLE), 8'(powerState));
        chk("alive rails", 8'h08, 8'(railEnable));
        deepPin = 1'b0;
        wr(8'h02, 8'h02);
        chk("pin off", 8'(PMICFS_PS_DEEP_OFF), 8'(powerState));
        standbyN = 1'b1;
        wr(8'h02, 8'h01);
        chk("bus idle", 8'(PMICFS_PS_DEEP_IDLE), 8'(powerState));
        wr(8'h02, 8'h00);
        cyc(2);
        chk("awake", 8'(PMICFS_PS_ACTIVE), 8'(powerState));
        $display("test sleep done");
    endtask

    // One-cycle undervolt on each rail latches until reset
    task automatic tUv();
        for (int r = 0; r < 4; r++) begin
            uv = 4'(1 << r);
            cyc(1);
            uv = 4'h0;
            cyc(3);
            chk("rails uv", 8'h00, 8'(railEnable));
            chk("pg uv", 8'h00, 8'(powerGoodOut));
            rchk("uv status", 8'h0D, 8'(8'h80 >> r));
            rchk("uv rail stat", 8'h0E, {4'(1 << r), 4'hF});
            rchk("uv kept", 8'h0D, 8'(8'h80 >> r));
            srst = 1'b1;
            cyc(2);
            srst = 1'b0;
            cyc(3);
            chk("rails after reset", 8'h0F, 8'(railEnable));
        end
        $display("test undervolt done");
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        srst = 1'b1;
        {dieOt, vinOv, gateReady, porMon, deepPin} = 5'h00;
        standbyN = 1'b1;
        uv = 4'h0;
        ov = 4'h0;
        pgIn = 4'hF;
        tReset();
        tIdent();
        tCore();
        tFault();
        tSleep();
        tUv();
        closeOut();
    end

    // Watchdog, about five times the expected run
    initial begin
        repeat (40000) @(posedge clock);
        nErrors++;
        closeOut();
    end
endmodule
`default_nettype wire
